// ---- rtl/rgp_pkg.sv ----
// Shared constants and types for the RGMII PHY port
package rgp_pkg;
    // Link speed selection
    typedef enum logic [1:0] {
        RGP_SPEED_10,
        RGP_SPEED_100,
        RGP_SPEED_1000
    } rgp_speed_t;

    // Clock rates, in kHz
    localparam int unsigned SYS_CLK_KHZ  = 250000;
    localparam int unsigned TXC_1000_KHZ = 125000;
    localparam int unsigned TXC_100_KHZ  = 25000;
    localparam int unsigned TXC_10_KHZ   = 2500;
    localparam int unsigned REFCLK_KHZ   = 25000;

    // Half periods in system clock cycles, rounded down, never below one
    localparam int unsigned HALF_1000_RAW = SYS_CLK_KHZ / (2 * TXC_1000_KHZ);
    localparam int unsigned HALF_100_RAW  = SYS_CLK_KHZ / (2 * TXC_100_KHZ);
    localparam int unsigned HALF_10_RAW   = SYS_CLK_KHZ / (2 * TXC_10_KHZ);
    localparam int unsigned HALF_REF_RAW  = SYS_CLK_KHZ / (2 * REFCLK_KHZ);
    localparam logic [7:0] HALF_1000 = 8'(HALF_1000_RAW < 1 ? 1 : HALF_1000_RAW);
    localparam logic [7:0] HALF_100  = 8'(HALF_100_RAW < 1 ? 1 : HALF_100_RAW);
    localparam logic [7:0] HALF_10   = 8'(HALF_10_RAW < 1 ? 1 : HALF_10_RAW);
    localparam logic [7:0] HALF_REF  = 8'(HALF_REF_RAW < 1 ? 1 : HALF_REF_RAW);

    // Reset values
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [7:0] COUNT_RST  = 8'h00;
    localparam logic [2:0] SYNC_RST   = 3'h0;
endpackage

// ---- rtl/rgp_rx_if.sv ----
// Carrier between the port top and its receive deserialiser
`timescale 1ns/1ps
interface rgp_rx_if;
    logic       gigabit;
    logic       rxc_pin;
    logic       rx_ctl_pin;
    logic [3:0] rxd_pin;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_error;

    modport top (output gigabit, output rxc_pin, output rx_ctl_pin, output rxd_pin,
                 input rx_byte, input rx_valid, input rx_error);
    modport rx  (input gigabit, input rxc_pin, input rx_ctl_pin, input rxd_pin,
                 output rx_byte, output rx_valid, output rx_error);
endinterface

// ---- rtl/rgp_rx.sv ----
// Receive side: samples the PHY's clock, data and control, builds bytes
`timescale 1ns/1ps
module rgp_rx
    import rgp_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    rgp_rx_if.rx      rif
);
    // Three-stage synchronisers for clock, control and data pins
    logic [2:0] rxc_sync_q;
    logic [2:0] ctl_sync_q;
    logic [2:0] rxd_sync_q [4];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rxc_sync_q <= SYNC_RST;
            ctl_sync_q <= SYNC_RST;
        end else begin
            rxc_sync_q <= {rxc_sync_q[1:0], rif.rxc_pin};
            ctl_sync_q <= {ctl_sync_q[1:0], rif.rx_ctl_pin};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rxd_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    rxd_sync_q[gi] <= SYNC_RST;
                end else begin
                    rxd_sync_q[gi] <= {rxd_sync_q[gi][1:0], rif.rxd_pin[gi]};
                end
            end
        end
    endgenerate

    // Edges are taken from the agreeing second and third stages only
    wire       rise = rxc_sync_q[1] & ~rxc_sync_q[2];
    wire       fall = ~rxc_sync_q[1] & rxc_sync_q[2];
    wire       ctl_now = ctl_sync_q[1];
    wire [3:0] nib_now = {rxd_sync_q[3][1], rxd_sync_q[2][1], rxd_sync_q[1][1], rxd_sync_q[0][1]};

    logic [3:0] low_q;
    logic       dv_q;
    logic       err_q;
    logic       half_q;
    logic [7:0] byte_q;
    logic       valid_q;
    logic       error_q;

    // Rising edge carries valid, falling carries valid xor error
    wire err_fall = dv_q ^ ctl_now;
    // Gigabit: byte done at falling edge; slower: at second rising nibble
    wire done_gig  = rif.gigabit & fall & dv_q;
    wire done_slow = ~rif.gigabit & rise & ctl_now & half_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low_q   <= NIBBLE_RST;
            dv_q    <= 1'b0;
            err_q   <= 1'b0;
            half_q  <= 1'b0;
            byte_q  <= BYTE_RST;
            valid_q <= 1'b0;
            error_q <= 1'b0;
        end else begin
            valid_q <= done_gig | done_slow;
            if (rise) begin
                dv_q <= ctl_now;
                if (rif.gigabit | ~half_q) begin
                    low_q <= nib_now;
                end
                half_q <= ~rif.gigabit & ctl_now & ~half_q;
            end
            if (fall) begin
                err_q <= err_fall;
            end
            if (done_gig) begin
                byte_q  <= {nib_now, low_q};
                error_q <= err_fall;
            end else if (done_slow) begin
                byte_q  <= {nib_now, low_q};
                error_q <= err_q;
            end
        end
    end

    assign rif.rx_byte  = byte_q;
    assign rif.rx_valid = valid_q;
    assign rif.rx_error = error_q;
endmodule

// ---- rtl/rgp_port.sv ----
// RGMII PHY port top: transmit serialiser, clocks toward the PHY, receive path
`timescale 1ns/1ps
// Operation
// - Send frame nibbles on four-bit TX bus
// - TX control carries enable and error combined
// - Drive TX clock at speed-dependent rate
// - Output free-running 25 MHz reference clock
// - TX clock may follow PHY gigabit clock
module rgp_port
    import rgp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire rgp_speed_t speed,
    input  wire logic       use_phy_clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_error,
    output logic            tx_taken,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_error,
    output logic [3:0]      txd,
    output logic            tx_ctl,
    output logic            txc,
    input  wire logic [3:0] rxd,
    input  wire logic       rx_ctl,
    input  wire logic       rxc,
    input  wire logic       phy_gigabit_clock_in,
    output logic            phy_reference_clock_out
);
    rgp_rx_if rif ();

    wire gigabit = (speed == RGP_SPEED_1000);

    // Reference clock divider, never stopped by speed changes
    logic [7:0] ref_cnt_q;
    logic       ref_q;
    wire        ref_wrap = (ref_cnt_q == HALF_REF - 8'h01);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_cnt_q <= COUNT_RST;
            ref_q     <= 1'b0;
        end else begin
            ref_cnt_q <= ref_wrap ? COUNT_RST : ref_cnt_q + 8'h01;
            ref_q     <= ref_q ^ ref_wrap;
        end
    end

    // PHY gigabit clock passes three stages before its edges are used
    logic [2:0] gclk_sync_q;
    wire        gclk_edge = gclk_sync_q[1] ^ gclk_sync_q[2];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gclk_sync_q <= SYNC_RST;
        end else begin
            gclk_sync_q <= {gclk_sync_q[1:0], phy_gigabit_clock_in};
        end
    end

    // Transmit clock divider; half period chosen by speed
    logic [7:0] tx_cnt_q;
    logic       txc_q;
    wire [7:0]  half = gigabit ? HALF_1000 :
                       (speed == RGP_SPEED_100) ? HALF_100 : HALF_10;
    wire        cnt_wrap = (tx_cnt_q >= half - 8'h01);
    // The synchronised PHY clock is used only at gigabit speed and only when use_phy_clk is set
    wire        ext_sel = gigabit & use_phy_clk;
    wire        toggle = ext_sel ? gclk_edge : cnt_wrap;
    wire        go_high = toggle & ~txc_q;
    wire        go_low = toggle & txc_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_cnt_q <= COUNT_RST;
            txc_q    <= 1'b0;
        end else begin
            tx_cnt_q <= (cnt_wrap | ext_sel) ? COUNT_RST : tx_cnt_q + 8'h01;
            txc_q    <= txc_q ^ toggle;
        end
    end

    // Byte under transmission
    logic [7:0] cur_q;
    logic       cur_en_q;
    logic       cur_er_q;
    logic       nib_sel_q;
    logic [3:0] txd_q;
    logic       tx_ctl_q;
    logic       taken_q;

    // Gigabit fetches a byte each rising edge; slower rates every other falling edge
    wire fetch = gigabit ? go_high : (go_low & ~nib_sel_q);
    wire en_now = fetch ? tx_valid : cur_en_q;
    wire er_now = fetch ? tx_valid & tx_error : cur_er_q;
    wire [7:0] byte_now = fetch ? tx_data : cur_q;

    // Next nibble and control level on the wire
    wire [3:0] gig_nib = go_high ? byte_now[3:0] : byte_now[7:4];
    wire       gig_ctl = go_high ? en_now : (en_now ^ er_now);
    // Slow rates change data on falling edges so the PHY's rising edge is centred
    wire [3:0] slow_nib = nib_sel_q ? cur_q[7:4] : byte_now[3:0];
    wire       slow_ctl = en_now ^ (er_now & nib_sel_q);
    wire       drive = gigabit ? toggle : go_low;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_q     <= BYTE_RST;
            cur_en_q  <= 1'b0;
            cur_er_q  <= 1'b0;
            nib_sel_q <= 1'b0;
            txd_q     <= NIBBLE_RST;
            tx_ctl_q  <= 1'b0;
            taken_q   <= 1'b0;
        end else begin
            taken_q <= fetch & tx_valid;
            if (fetch) begin
                cur_q    <= tx_data;
                cur_en_q <= tx_valid;
                cur_er_q <= tx_valid & tx_error;
            end
            if (gigabit) begin
                nib_sel_q <= 1'b0;
            end else if (go_low) begin
                nib_sel_q <= ~nib_sel_q & en_now;
            end
            if (drive) begin
                txd_q    <= gigabit ? gig_nib : slow_nib;
                tx_ctl_q <= gigabit ? gig_ctl : slow_ctl;
            end
        end
    end

    // Receive path
    assign rif.gigabit    = gigabit;
    assign rif.rxc_pin    = rxc;
    assign rif.rx_ctl_pin = rx_ctl;
    assign rif.rxd_pin    = rxd;

    rgp_rx u_rx (
        .sys_clk (sys_clk),
        .rst     (rst),
        .rif     (rif)
    );

    assign txd                     = txd_q;
    assign tx_ctl                  = tx_ctl_q;
    assign txc                     = txc_q;
    assign tx_taken                = taken_q;
    assign phy_reference_clock_out = ref_q;
    assign rx_data                 = rif.rx_byte;
    assign rx_valid                = rif.rx_valid;
    assign rx_error                = rif.rx_error;
endmodule

// ---- tb/rgp_port_asserts.sv ----
// Pin timing checker for the RGMII port
`timescale 1ns/1ps
module rgp_port_asserts
    import rgp_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire rgp_speed_t speed,
    input wire logic       use_phy_clk,
    input wire logic       tx_taken,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic [3:0] txd,
    input wire logic       tx_ctl,
    input wire logic       txc,
    input wire logic       phy_reference_clock_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Reference clock: five cycles per level, never stops
    sequence ref_half;
        $stable(phy_reference_clock_out)[*4] ##1 $changed(phy_reference_clock_out);
    endsequence
    // Slow clock: five cycles high at 100 Mb/s
    sequence txc_high_100;
        $stable(txc)[*4] ##1 $fell(txc);
    endsequence
    a_ref_period: assert property ($changed(phy_reference_clock_out) |=> ref_half)
        else $error("reference clock period wrong");
    a_gig_toggle: assert property (speed == RGP_SPEED_1000 && !use_phy_clk && !$past(rst)
        && !$past(rst, 2) |-> txc != $past(txc))
        else $error("gigabit transmit clock not toggling");
    a_slow_half: assert property (speed == RGP_SPEED_100 && $rose(txc) |=> txc_high_100)
        else $error("transmit clock half period wrong");
    a_txd_edge: assert property ($changed(txd) |-> $changed(txc))
        else $error("data moved without clock edge");
    a_slow_data: assert property (speed != RGP_SPEED_1000 && $changed(txd) |-> $fell(txc))
        else $error("slow data not on falling edge");
    a_ctl_taken: assert property ($rose(tx_ctl) |-> tx_taken)
        else $error("control rose without byte taken");
    a_taken_pulse: assert property (tx_taken |=> !tx_taken)
        else $error("taken longer than one cycle");
    a_rx_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("receive valid longer than one cycle");
    a_rx_hold: assert property ($changed(rx_data) |-> rx_valid)
        else $error("receive data moved without valid");
endmodule
bind rgp_port rgp_port_asserts rgp_port_asserts_inst (.sys_clk, .rst, .speed, .use_phy_clk,
    .tx_taken, .rx_data, .rx_valid, .txd, .tx_ctl, .txc, .phy_reference_clock_out);

// ---- tb/rgp_phy_model.sv ----
// Behavioural PHY driving the receive pins at 125 ns per clock period, one nibble per period or two in DDR mode
`timescale 1ns/1ps
module rgp_phy_model (
    output logic       rxc,
    output logic       rx_ctl,
    output logic [3:0] rxd
);
    initial begin
        rxc = 1'b0;
        rx_ctl = 1'b0;
        rxd = 4'h0;
    end
    // Clock rests low between frames; released data is inverted, not held
    // Falling-edge control is set a quarter period ahead and held past the edge
    task automatic send(input logic [7:0] b, input logic en, input logic er, input logic ddr);
        for (int i = 0; i < (ddr ? 1 : 2); i++) begin
            rxd = i ? b[7:4] : b[3:0];
            rx_ctl = en;
            #31.25 rxc = 1'b1;
            #31.25 rx_ctl = en ^ er;
            if (ddr) rxd = b[7:4];
            #31.25 rxc = 1'b0;
            #31.25;
        end
        rxd = ~rxd;
        rx_ctl = 1'b0;
    endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the RGMII port
`timescale 1ns/1ps
module testbench;
    import rgp_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    rgp_speed_t speed = RGP_SPEED_1000;
    logic       use_phy_clk = 1'b0;
    logic       tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       tx_error = 1'b0;
    logic       phy_clk = 1'b0;
    logic       tx_taken, rx_valid, rx_error, tx_ctl, txc, rx_ctl, rxc, ref_out, got_err;
    logic [7:0] rx_data, got;
    logic [3:0] txd, rxd;
    int         err_count = 0;
    int         compares = 0;
    int         got_cnt = 0;
    always #2 sys_clk = ~sys_clk;
    // PHY's 125 MHz clock, offset from the sampling edge
    always #4 phy_clk = ~phy_clk;
    rgp_port rgp_port_inst (.sys_clk, .rst, .speed, .use_phy_clk, .tx_valid, .tx_data,
        .tx_error, .tx_taken, .rx_data, .rx_valid, .rx_error, .txd, .tx_ctl, .txc, .rxd,
        .rx_ctl, .rxc, .phy_gigabit_clock_in(phy_clk), .phy_reference_clock_out(ref_out));
    rgp_phy_model rgp_phy_model_inst (.rxc, .rx_ctl, .rxd);
    // Capture every received byte away from the edge that launches it
    always @(negedge sys_clk) begin
        if (rx_valid === 1'b1) begin
            got <= rx_data;
            got_err <= rx_error;
            got_cnt <= got_cnt + 1;
        end
    end
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Speed and clock source only change under reset
    task automatic do_reset(input rgp_speed_t s, input logic p);
        @(negedge sys_clk);
        rst = 1'b1;
        speed = s;
        use_phy_clk = p;
        repeat (10) @(negedge sys_clk);
        check({txd, tx_ctl, txc, tx_taken, rx_valid}, 8'h00);
        rst = 1'b0;
    endtask
    // One byte out; low nibble first, span between the two nibble edges measured
    task automatic test_tx(input rgp_speed_t s, input logic p, input logic [7:0] d,
                           input logic er);
        logic       last, gig;
        logic [3:0] lo;
        int         t0, n, tk;
        do_reset(s, p);
        tk = 0;
        gig = (s == RGP_SPEED_1000);
        tx_data = d;
        tx_error = er;
        tx_valid = 1'b1;
        last = txc;
        n = 0;
        t0 = 0;
        for (int i = 0; i < 600 && n < 2; i++) begin
            @(negedge sys_clk);
            if (tx_taken === 1'b1) begin
                tx_valid = 1'b0;
                tk++;
            end
            if (txc !== last && txc === (gig && n == 0) && (n == 1 || tx_ctl === 1'b1)) begin
                if (n == 0) lo = txd;
                if (n == 0) t0 = i;
                if (n == 1) check({4'h0, txd}, {4'h0, d[7:4]});
                if (n == 1) check({7'h00, tx_ctl}, {7'h00, ~er});
                if (n == 1) check(8'(i - t0), gig ? 8'h01 : 8'(SYS_CLK_KHZ /
                    (s == RGP_SPEED_100 ? TXC_100_KHZ : TXC_10_KHZ)));
                n++;
            end
            last = txc;
        end
        tx_valid = 1'b0;
        check(8'(n), 8'h02);
        check(8'(tk), 8'h01);
        check({4'h0, lo}, {4'h0, d[3:0]});
        $display("transmit test done at %0t", $time);
    endtask
    // One byte in; gigabit packs both nibbles in one period; control low drops it
    task automatic test_rx(input rgp_speed_t s, input logic [7:0] d, input logic en,
                           input logic er);
        int c0;
        do_reset(s, 1'b0);
        c0 = got_cnt;
        rgp_phy_model_inst.send(d, en, er, s == RGP_SPEED_1000);
        repeat (20) @(negedge sys_clk);
        check(8'(got_cnt - c0), {7'h00, en});
        if (en) check(got, d);
        if (en) check({7'h00, got_err}, {7'h00, er});
        $display("receive test done at %0t", $time);
    endtask
    // Reference clock keeps its 25 MHz rate at the gigabit link speed left by the last receive test
    task automatic test_ref();
        logic last;
        int   n;
        last = ref_out;
        n = 0;
        for (int i = 0; i < 100; i++) begin
            @(negedge sys_clk);
            if (ref_out !== last) n++;
            last = ref_out;
        end
        check(8'(n), 8'(200 * REFCLK_KHZ / SYS_CLK_KHZ));
        $display("reference clock test done at %0t", $time);
    endtask
    initial begin
        test_tx(RGP_SPEED_1000, 1'b0, 8'hA5, 1'b0);
        test_tx(RGP_SPEED_1000, 1'b1, 8'h3C, 1'b1);
        test_tx(RGP_SPEED_100, 1'b0, 8'h96, 1'b1);
        test_tx(RGP_SPEED_10, 1'b0, 8'h5A, 1'b0);
        test_rx(RGP_SPEED_100, 8'hC3, 1'b1, 1'b0);
        test_rx(RGP_SPEED_100, 8'h7E, 1'b1, 1'b1);
        test_rx(RGP_SPEED_100, 8'h81, 1'b0, 1'b0);
        test_rx(RGP_SPEED_1000, 8'h5C, 1'b1, 1'b1);
        test_ref();
        report_and_stop();
    end
    // Tests need about 3 us; a hang is cut off well beyond that
    initial begin
        #50000;
        err_count++;
        report_and_stop();
    end
endmodule
